// ### inc/idbs_cfg.svh
`ifndef IDBS_CFG_SVH
`define IDBS_CFG_SVH
// datapath widths
`define IDBS_WORD_W 16
`define IDBS_DWORD_W 32
`define IDBS_REG_SEL_W 4
// shift amount field width, largest shift 15
`define IDBS_SHAMT_W 4
// iteration counter width and divide iteration count (one per divisor bit)
`define IDBS_CNT_W 5
`define IDBS_DIV_ITER 5'h10
// fixed destination registers for quotient and remainder
`define IDBS_QUOT_REG 4'h0
`define IDBS_REM_REG 4'h1
`endif

// ### inc/idbs_pkg.sv
package idbs_pkg;
  // operation codes presented by the decoder
  typedef enum logic [2:0] {
    IDBS_OP_NONE = 3'h0,
    IDBS_OP_ARITHMETIC_RIGHT_SHIFT = 3'h1,
    IDBS_OP_SHIFT_LEFT = 3'h2,
    IDBS_OP_LOGICAL_RIGHT_SHIFT = 3'h3,
    IDBS_OP_DIV = 3'h4
  } idbs_op_t;
  // divider states, one-hot
  typedef enum logic [2:0] {
    IDBS_DV_IDLE = 3'b001,
    IDBS_DV_RUN = 3'b010,
    IDBS_DV_DONE = 3'b100
  } idbs_dv_state_t;
endpackage : idbs_pkg

// ### inc/idbs_div_if.sv
`timescale 1ns/1ps
`include "idbs_cfg.svh"
// start/operands to the divide engine, results back
interface idbs_div_if;
  logic start;
  logic is_signed;
  logic [`IDBS_DWORD_W-1:0] dividend;
  logic [`IDBS_WORD_W-1:0] divisor;
  logic busy;
  logic done;
  logic [`IDBS_WORD_W-1:0] quotient;
  logic [`IDBS_WORD_W-1:0] remainder;
  modport ctrl (output start, is_signed, dividend, divisor, input busy, done, quotient, remainder);
  modport eng (input start, is_signed, dividend, divisor, output busy, done, quotient, remainder);
endinterface : idbs_div_if

// ### rtl/idbs_shifter.sv
`timescale 1ns/1ps
`include "idbs_cfg.svh"
// single-cycle barrel shifter
module idbs_shifter (
  input wire logic [2:0] op,
  input wire logic [`IDBS_WORD_W-1:0] src,
  input wire logic [`IDBS_SHAMT_W-1:0] shamt,
  output logic [`IDBS_WORD_W-1:0] res
);
  logic [`IDBS_WORD_W-1:0] stage [0:`IDBS_SHAMT_W];
  logic fill;
  assign fill = (op == 3'h1) ? src[`IDBS_WORD_W-1] : 1'b0;
  assign stage[0] = src;
  // log stages: one per bit of shift amount
  genvar g;
  generate
    for (g = 0; g < `IDBS_SHAMT_W; g++) begin : g_stage
      localparam int N = 1 << g;
      always_comb begin
        if (!shamt[g]) begin
          stage[g+1] = stage[g];
        end else if (op == 3'h2) begin
          stage[g+1] = {stage[g][`IDBS_WORD_W-1-N:0], {N{1'b0}}};
        end else begin
          // sign fill high; zero fill high
          stage[g+1] = {{N{fill}}, stage[g][`IDBS_WORD_W-1:N]};
        end
      end
    end
  endgenerate
  assign res = stage[`IDBS_SHAMT_W];
endmodule : idbs_shifter

// ### rtl/idbs_divider.sv
`timescale 1ns/1ps
`include "idbs_cfg.svh"
// iterative restoring divider, 16 iterations
module idbs_divider (
  input wire logic sys_clk,
  input wire logic srst,
  idbs_div_if.eng dv
);
  typedef struct packed {
    idbs_pkg::idbs_dv_state_t st;
    logic [`IDBS_CNT_W-1:0] cnt;
    logic [`IDBS_DWORD_W-1:0] num;
    logic [`IDBS_WORD_W:0] rem;
    logic [`IDBS_WORD_W-1:0] den;
    logic neg_q;
    logic neg_r;
    logic [`IDBS_WORD_W-1:0] q;
    logic [`IDBS_WORD_W-1:0] r;
  } idbs_dv_s_t;
  idbs_dv_s_t s_q, s_d;
  logic [`IDBS_WORD_W:0] trial;
  always_comb begin
    s_d = s_q;
    trial = '0;
    case (s_q.st)
      idbs_pkg::IDBS_DV_IDLE: begin
        if (dv.start) begin
          s_d.neg_q = dv.is_signed & (dv.dividend[`IDBS_DWORD_W-1] ^ dv.divisor[`IDBS_WORD_W-1]);
          s_d.neg_r = dv.is_signed & dv.dividend[`IDBS_DWORD_W-1];
          s_d.num = (dv.is_signed && dv.dividend[`IDBS_DWORD_W-1]) ? -dv.dividend : dv.dividend;
          s_d.den = (dv.is_signed && dv.divisor[`IDBS_WORD_W-1]) ? -dv.divisor : dv.divisor;
          // high half seeds partial remainder; low half shifts in
          s_d.rem = {1'b0, s_d.num[`IDBS_DWORD_W-1:`IDBS_WORD_W]};
          s_d.cnt = '0;
          s_d.st = idbs_pkg::IDBS_DV_RUN;
        end
      end
      idbs_pkg::IDBS_DV_RUN: begin
        trial = {s_q.rem[`IDBS_WORD_W-1:0], s_q.num[`IDBS_WORD_W-1]};
        s_d.num = {s_q.num[`IDBS_DWORD_W-1:`IDBS_WORD_W], s_q.num[`IDBS_WORD_W-2:0], 1'b0};
        if (trial >= {1'b0, s_q.den}) begin
          s_d.rem = trial - {1'b0, s_q.den};
          s_d.num[0] = 1'b1;
        end else begin
          s_d.rem = trial;
        end
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_d.cnt == `IDBS_DIV_ITER) begin
          s_d.q = s_q.neg_q ? -s_d.num[`IDBS_WORD_W-1:0] : s_d.num[`IDBS_WORD_W-1:0];
          s_d.r = s_q.neg_r ? -s_d.rem[`IDBS_WORD_W-1:0] : s_d.rem[`IDBS_WORD_W-1:0];
          s_d.st = idbs_pkg::IDBS_DV_DONE;
        end
      end
      idbs_pkg::IDBS_DV_DONE: s_d.st = idbs_pkg::IDBS_DV_IDLE;
      default: s_d.st = idbs_pkg::IDBS_DV_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '{st: idbs_pkg::IDBS_DV_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  assign dv.busy = (s_q.st != idbs_pkg::IDBS_DV_IDLE);
  assign dv.done = (s_q.st == idbs_pkg::IDBS_DV_DONE);
  assign dv.quotient = s_q.q;
  assign dv.remainder = s_q.r;
endmodule : idbs_divider

// ### rtl/idbs_datapath.sv
`timescale 1ns/1ps
`include "idbs_cfg.svh"
module idbs_datapath (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic div_long,
  input wire logic div_signed,
  input wire logic [`IDBS_REG_SEL_W-1:0] src_sel,
  input wire logic [`IDBS_REG_SEL_W-1:0] divisor_source_reg,
  input wire logic [`IDBS_REG_SEL_W-1:0] dst_sel,
  input wire logic [`IDBS_SHAMT_W-1:0] shamt,
  input wire logic [`IDBS_WORD_W-1:0] rd_data_a,
  input wire logic [`IDBS_WORD_W-1:0] rd_data_b,
  input wire logic [`IDBS_WORD_W-1:0] rd_data_c,
  output logic [`IDBS_REG_SEL_W-1:0] rd_sel_a,
  output logic [`IDBS_REG_SEL_W-1:0] rd_sel_b,
  output logic [`IDBS_REG_SEL_W-1:0] rd_sel_c,
  output logic op_ready,
  output logic wr_en,
  output logic [`IDBS_REG_SEL_W-1:0] wr_sel,
  output logic [`IDBS_WORD_W-1:0] wr_data,
  output logic wr2_en,
  output logic [`IDBS_REG_SEL_W-1:0] wr2_sel,
  output logic [`IDBS_WORD_W-1:0] wr2_data,
  output logic div_done
);
  // ********************
  // divider and shifter
  // ********************
  idbs_div_if dv ();
  idbs_divider u_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .dv(dv.eng)
  );
  logic [`IDBS_WORD_W-1:0] sh_res;
  logic [`IDBS_WORD_W-1:0] lo_word;
  // source is the named register, odd or even
  assign lo_word = src_sel[0] ? rd_data_b : rd_data_a;
  // multi-bit shift in the same cycle
  idbs_shifter u_sh (
    .op(op_code),
    .src(lo_word),
    .shamt(shamt),
    .res(sh_res)
  );

  // ********************
  // operand selection
  // ********************
  // even register holds low half, odd partner high half
  assign rd_sel_a = {src_sel[`IDBS_REG_SEL_W-1:1], 1'b0};
  assign rd_sel_b = {src_sel[`IDBS_REG_SEL_W-1:1], 1'b1};
  assign rd_sel_c = divisor_source_reg;
  logic is_div;
  logic is_shift;
  logic accept;
  assign is_div = op_valid && (op_code == idbs_pkg::IDBS_OP_DIV);
  assign is_shift = op_valid && (op_code == idbs_pkg::IDBS_OP_ARITHMETIC_RIGHT_SHIFT
                                 || op_code == idbs_pkg::IDBS_OP_SHIFT_LEFT
                                 || op_code == idbs_pkg::IDBS_OP_LOGICAL_RIGHT_SHIFT);
  // no new operation while divide runs
  assign accept = !dv.busy && op_ready;
  // for a 16-bit dividend the source register is sign-extended when signed, zero-extended otherwise
  always_comb begin
    dv.start = is_div && accept;
    dv.is_signed = div_signed;
    if (div_long) begin
      dv.dividend = {rd_data_b, rd_data_a};
    end else if (div_signed) begin
      dv.dividend = {{`IDBS_WORD_W{lo_word[`IDBS_WORD_W-1]}}, lo_word};
    end else begin
      dv.dividend = {{`IDBS_WORD_W{1'b0}}, lo_word};
    end
    dv.divisor = rd_data_c;
  end

  // ********************
  // result registers
  // ********************
  typedef struct packed {
    logic rdy;
    logic we;
    logic [`IDBS_REG_SEL_W-1:0] ws;
    logic [`IDBS_WORD_W-1:0] wd;
    logic we2;
    logic [`IDBS_REG_SEL_W-1:0] ws2;
    logic [`IDBS_WORD_W-1:0] wd2;
    logic dn;
  } idbs_dp_s_t;
  idbs_dp_s_t s_q, s_d;
  // write-back next state
  always_comb begin
    s_d = s_q;
    s_d.we = 1'b0;
    s_d.we2 = 1'b0;
    s_d.dn = 1'b0;
    s_d.rdy = !(dv.busy || dv.start);
    if (is_shift && accept) begin
      s_d.we = 1'b1;
      s_d.ws = dst_sel;
      s_d.wd = sh_res;
    end
    if (dv.done) begin
      s_d.we = 1'b1;
      s_d.ws = `IDBS_QUOT_REG;
      s_d.wd = dv.quotient;
      s_d.we2 = 1'b1;
      s_d.ws2 = `IDBS_REM_REG;
      s_d.wd2 = dv.remainder;
      s_d.dn = 1'b1;
    end
  end
  // registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q <= '{rdy: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  assign op_ready = s_q.rdy;
  assign wr_en = s_q.we;
  assign wr_sel = s_q.ws;
  assign wr_data = s_q.wd;
  assign wr2_en = s_q.we2;
  assign wr2_sel = s_q.ws2;
  assign wr2_data = s_q.wd2;
  assign div_done = s_q.dn;
endmodule : idbs_datapath

// ### tb/idbs_checker.sv
`timescale 1ns/1ps
// port-level timing and routing checks
module idbs_checker (
  input logic sys_clk,
  input logic srst,
  input logic op_valid,
  input logic [2:0] op_code,
  input logic div_long,
  input logic [3:0] src_sel,
  input logic [3:0] divisor_source_reg,
  input logic [3:0] dst_sel,
  input logic [3:0] rd_sel_b,
  input logic [3:0] rd_sel_c,
  input logic op_ready,
  input logic wr_en,
  input logic [3:0] wr_sel,
  input logic wr2_en,
  input logic [3:0] wr2_sel,
  input logic div_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // accepted divide, accepted shift, quiet run
  sequence s_dv; op_valid && op_ready && op_code == 3'h4; endsequence
  sequence s_sh; op_valid && op_ready && op_code inside {3'h1, 3'h2, 3'h3}; endsequence
  sequence s_run; (!op_ready && !div_done) [*8]; endsequence
  a_shift_next: assert property (s_sh |=> wr_en && wr_sel == $past(dst_sel))
    else $error("shift write missing");
  a_div_busy: assert property (s_dv |=> s_run ##1 s_run)
    else $error("divide not busy");
  a_div_time: assert property (s_dv |-> ##18 div_done)
    else $error("divide late");
  a_quot_dest: assert property (div_done |-> wr_en && wr_sel == 4'h0)
    else $error("quotient misplaced");
  a_rem_dest: assert property (div_done |-> wr2_en && wr2_sel == 4'h1)
    else $error("remainder misplaced");
  a_ready_back: assert property (div_done |=> op_ready)
    else $error("ready not back");
  a_pair_high: assert property (s_dv |-> !div_long || rd_sel_b == {src_sel[3:1], 1'b1})
    else $error("pair select wrong");
  a_divisor_pick: assert property (s_dv |-> rd_sel_c == divisor_source_reg)
    else $error("divisor select wrong");
  a_write_cause: assert property (wr_en && !div_done |-> $past(op_valid && op_ready))
    else $error("stray write");
endmodule : idbs_checker
bind idbs_datapath idbs_checker i_chk (
  .sys_clk(sys_clk),
  .srst(srst),
  .op_valid(op_valid),
  .op_code(op_code),
  .div_long(div_long),
  .src_sel(src_sel),
  .divisor_source_reg(divisor_source_reg),
  .dst_sel(dst_sel),
  .rd_sel_b(rd_sel_b),
  .rd_sel_c(rd_sel_c),
  .op_ready(op_ready),
  .wr_en(wr_en),
  .wr_sel(wr_sel),
  .wr2_en(wr2_en),
  .wr2_sel(wr2_sel),
  .div_done(div_done)
);

// ### tb/idbs_rf_model.sv
`timescale 1ns/1ps
// working register file seen by the datapath
module idbs_rf_model (
  input logic sys_clk,
  input logic [3:0] rd_sel_a,
  input logic [3:0] rd_sel_b,
  input logic [3:0] rd_sel_c,
  output logic [15:0] rd_data_a,
  output logic [15:0] rd_data_b,
  output logic [15:0] rd_data_c,
  input logic wr_en,
  input logic [3:0] wr_sel,
  input logic [15:0] wr_data,
  input logic wr2_en,
  input logic [3:0] wr2_sel,
  input logic [15:0] wr2_data
);
  logic [15:0] r [16];
  // same-cycle reads
  assign rd_data_a = r[rd_sel_a];
  assign rd_data_b = r[rd_sel_b];
  assign rd_data_c = r[rd_sel_c];
  // two write ports
  always @(posedge sys_clk) begin
    if (wr_en) r[wr_sel] <= wr_data;
    if (wr2_en) r[wr2_sel] <= wr2_data;
  end
endmodule : idbs_rf_model

// ### tb/testbench.sv
`timescale 1ns/1ps
// self-checking bench of shifts and divides
module testbench;
  logic sys_clk, srst, op_valid, div_long, div_signed, op_ready, wr_en, wr2_en, div_done;
  logic [2:0] op_code;
  logic [3:0] src_sel, divisor_source_reg, dst_sel, shamt, rd_sel_a, rd_sel_b, rd_sel_c;
  logic [3:0] wr_sel, wr2_sel;
  logic [15:0] rd_data_a, rd_data_b, rd_data_c, wr_data, wr2_data, lfsr, v, b;
  logic [31:0] a, e;
  int fail_count = 0;
  int checked = 0;
  idbs_datapath i_dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .op_valid(op_valid),
    .op_code(op_code),
    .div_long(div_long),
    .div_signed(div_signed),
    .src_sel(src_sel),
    .divisor_source_reg(divisor_source_reg),
    .dst_sel(dst_sel),
    .shamt(shamt),
    .rd_data_a(rd_data_a),
    .rd_data_b(rd_data_b),
    .rd_data_c(rd_data_c),
    .rd_sel_a(rd_sel_a),
    .rd_sel_b(rd_sel_b),
    .rd_sel_c(rd_sel_c),
    .op_ready(op_ready),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .wr2_en(wr2_en),
    .wr2_sel(wr2_sel),
    .wr2_data(wr2_data),
    .div_done(div_done)
  );
  idbs_rf_model i_rf (
    .sys_clk(sys_clk),
    .rd_sel_a(rd_sel_a),
    .rd_sel_b(rd_sel_b),
    .rd_sel_c(rd_sel_c),
    .rd_data_a(rd_data_a),
    .rd_data_b(rd_data_b),
    .rd_data_c(rd_data_c),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .wr2_en(wr2_en),
    .wr2_sel(wr2_sel),
    .wr2_data(wr2_data)
  );
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // random source and expected results
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : step
  function automatic logic [15:0] sh_exp(input logic [2:0] o, input logic [15:0] x,
                                         input logic [3:0] s);
    if (o == 3'h1) return $signed(x) >>> s;
    if (o == 3'h2) return x << s;
    return x >> s;
  endfunction : sh_exp
  function automatic logic [31:0] dv_exp(input logic sg, input logic [31:0] x,
                                         input logic [15:0] y);
    logic signed [31:0] q, r;
    // separate branches keep the signed divide signed
    if (sg) begin
      q = $signed(x) / $signed({{16{y[15]}}, y});
      r = $signed(x) % $signed({{16{y[15]}}, y});
    end else begin
      q = x / y;
      r = x % y;
    end
    return {r[15:0], q[15:0]};
  endfunction : dv_exp
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // one shift, random source and destination
  task automatic do_shift(input logic [2:0] o, input logic [3:0] s);
    v = step(lfsr);
    lfsr = step(v);
    i_rf.r[lfsr[3:0]] <= v;
    src_sel <= lfsr[3:0];
    dst_sel <= lfsr[7:4];
    shamt <= s;
    op_code <= o;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    @(posedge sys_clk);
    chk("shift write", 16'h1, {15'h0, wr_en});
    chk("shift dest", {12'h0, lfsr[7:4]}, {12'h0, wr_sel});
    chk("shift data", sh_exp(o, v, s), wr_data);
    // let the result land before the next register preset
    @(posedge sys_clk);
  endtask : do_shift
  // one divide, a shift offered meanwhile
  task automatic do_div(input logic lg, input logic sg);
    int n;
    b = step(lfsr);
    lfsr = step(b);
    b = sg ? {b[15:2], 2'b10} : {1'b1, b[14:0]};
    a = {sg ? {16{lfsr[15]}} : {1'b0, v[14:0]}, lfsr};
    e = dv_exp(sg, (lg || sg) ? a : {16'h0, a[15:0]}, b);
    i_rf.r[{lfsr[3:1], 1'b0}] <= a[15:0];
    i_rf.r[{lfsr[3:1], 1'b1}] <= a[31:16];
    i_rf.r[{~lfsr[3], lfsr[6:4]}] <= b;
    divisor_source_reg <= {~lfsr[3], lfsr[6:4]};
    src_sel <= {lfsr[3:1], lg & lfsr[9]};
    {div_long, div_signed, op_code, op_valid} <= {lg, sg, 3'h4, 1'b1};
    @(posedge sys_clk);
    op_code <= 3'h2;
    for (n = 1; n < 40; n++) begin
      @(posedge sys_clk);
      if (div_done === 1'b1) break;
      chk("refused write", 16'h0, {15'h0, wr_en});
    end
    op_valid <= 1'b0;
    chk("div cycles", 16'h12, n[15:0]);
    chk("quotient", e[15:0], wr_data);
    chk("remainder", e[31:16], wr2_data);
    @(posedge sys_clk);
    if (n == 40) give_verdict();
  endtask : do_div
  // reset, shift corners and random, every divide form
  initial begin
    lfsr = 16'hbddf;
    v = 16'h0;
    {srst, op_valid, div_long, div_signed, op_code} = 7'h40;
    {src_sel, divisor_source_reg, dst_sel, shamt} = 16'h0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk("idle", 16'h4, {13'h0, op_ready, wr_en, wr2_en});
    for (int k = 0; k < 48; k++) begin
      do_shift(3'(k % 3 + 1), k < 3 ? 4'h0 : k < 6 ? 4'h1 : k < 9 ? 4'hf : lfsr[3:0]);
    end
    for (int k = 0; k < 32; k++) do_div(k[0], k[1]);
    give_verdict();
  end
endmodule : testbench
